// ### src/jbs_tap.sv
// Boundary scan test access port: TAP controller, instruction and data registers.
// Assumes the test pins arrive asynchronously and are oversampled by clk.
`timescale 1ns/100ps
`default_nettype none
`include "jbs_defines.svh"

module jbs_tap #(
  // Identification fields; values are arbitrary
  parameter logic [10:0] MFR_ID = 11'h2A5,
  parameter logic [15:0] PART_ID = 16'h1234,
  parameter logic [3:0] VERSION = 4'h1,
  // User code value; arbitrary
  parameter logic [`JBS_ID_W-1:0] USER_CODE = 32'h0000_0000
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Test access pins
  input wire jbs_pkg::jbs_jtag_in_type jtag_in,
  output logic tdo,
  output logic tdo_oe,
  // Configuration state
  input wire logic programmed,
  output logic io_en,
  // Core side of the user I/O
  input wire jbs_pkg::jbs_drive_type [`JBS_N_IO-1:0] core_drive,
  output logic [`JBS_N_IO-1:0] core_in,
  // Pad side of the user I/O
  input wire logic [`JBS_N_IO-1:0] pad_in,
  output jbs_pkg::jbs_drive_type [`JBS_N_IO-1:0] pad_drive,
  // Observation
  output jbs_pkg::jbs_state_type tap_state
);
  import jbs_pkg::*;

  localparam int NC = `JBS_N_IO * `JBS_CELLS_PER_IO;

  // Next TAP state from the sampled mode select
  function automatic jbs_state_type tap_next(input jbs_state_type s, input logic m);
    unique case (s)
      JBS_RESET: tap_next = m ? JBS_RESET : JBS_IDLE;
      JBS_IDLE: tap_next = m ? JBS_SEL_DR : JBS_IDLE;
      JBS_SEL_DR: tap_next = m ? JBS_SEL_IR : JBS_CAP_DR;
      JBS_CAP_DR: tap_next = m ? JBS_EX1_DR : JBS_SHIFT_DR;
      JBS_SHIFT_DR: tap_next = m ? JBS_EX1_DR : JBS_SHIFT_DR;
      JBS_EX1_DR: tap_next = m ? JBS_UPD_DR : JBS_PAUSE_DR;
      JBS_PAUSE_DR: tap_next = m ? JBS_EX2_DR : JBS_PAUSE_DR;
      JBS_EX2_DR: tap_next = m ? JBS_UPD_DR : JBS_SHIFT_DR;
      JBS_UPD_DR: tap_next = m ? JBS_SEL_DR : JBS_IDLE;
      JBS_SEL_IR: tap_next = m ? JBS_RESET : JBS_CAP_IR;
      JBS_CAP_IR: tap_next = m ? JBS_EX1_IR : JBS_SHIFT_IR;
      JBS_SHIFT_IR: tap_next = m ? JBS_EX1_IR : JBS_SHIFT_IR;
      JBS_EX1_IR: tap_next = m ? JBS_UPD_IR : JBS_PAUSE_IR;
      JBS_PAUSE_IR: tap_next = m ? JBS_EX2_IR : JBS_PAUSE_IR;
      JBS_EX2_IR: tap_next = m ? JBS_UPD_IR : JBS_SHIFT_IR;
      JBS_UPD_IR: tap_next = m ? JBS_SEL_DR : JBS_IDLE;
    endcase
  endfunction

  // Data register addressed by an opcode
  function automatic jbs_dr_sel_type dr_select(input logic [`JBS_IR_W-1:0] op);
    unique case (op)
      `JBS_OP_EXTEST, `JBS_OP_SAMPLE: dr_select = JBS_DR_BSR;
      `JBS_OP_IDCODE: dr_select = JBS_DR_IDCODE;
      `JBS_OP_USERCODE: dr_select = JBS_DR_USER;
      default: dr_select = JBS_DR_BYPASS;
    endcase
  endfunction

  // Pin synchronisers; idle level high stands in for the pull-ups
  logic tck_s1_r, tck_s2_r, tck_d_r;
  logic tms_s1_r, tms_s2_r;
  logic tdi_s1_r, tdi_s2_r;
  logic trst_s1_r, trst_s2_r;
  logic [`JBS_N_IO-1:0] pad_s1_r, pad_s2_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tck_s1_r <= 1'h0;
      tck_s2_r <= 1'h0;
      tck_d_r <= 1'h0;
      tms_s1_r <= `JBS_PIN_IDLE;
      tms_s2_r <= `JBS_PIN_IDLE;
      tdi_s1_r <= `JBS_PIN_IDLE;
      tdi_s2_r <= `JBS_PIN_IDLE;
      trst_s1_r <= `JBS_PIN_IDLE;
      trst_s2_r <= `JBS_PIN_IDLE;
      pad_s1_r <= '0;
      pad_s2_r <= '0;
    end else if (ce) begin
      tck_s1_r <= jtag_in.tck;
      tck_s2_r <= tck_s1_r;
      tck_d_r <= tck_s2_r;
      tms_s1_r <= jtag_in.tms;
      tms_s2_r <= tms_s1_r;
      tdi_s1_r <= jtag_in.tdi;
      tdi_s2_r <= tdi_s1_r;
      trst_s1_r <= jtag_in.trst_n;
      trst_s2_r <= trst_s1_r;
      pad_s1_r <= pad_in;
      pad_s2_r <= pad_s1_r;
    end
  end

  // Test clock edges, from the second synchroniser stage and its one-clk delayed copy
  logic tck_rise, tck_fall, trst_act;
  assign tck_rise = tck_s2_r & ~tck_d_r;
  assign tck_fall = ~tck_s2_r & tck_d_r;
  assign trst_act = ~trst_s2_r;

  // TAP controller
  jbs_state_type state_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= JBS_RESET;
    end else if (ce) begin
      if (trst_act) begin
        state_r <= JBS_RESET;
      end else if (tck_rise) begin
        state_r <= tap_next(state_r, tms_s2_r);
      end
    end
  end

  // Instruction register: shift stage and held instruction
  logic [`JBS_IR_W-1:0] ir_shift_r, ir_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ir_shift_r <= '0;
      ir_r <= `JBS_OP_IDCODE;
    end else if (ce) begin
      if (trst_act || state_r == JBS_RESET) begin
        ir_r <= `JBS_OP_IDCODE;
      end else if (tck_rise && state_r == JBS_CAP_IR) begin
        ir_shift_r <= `JBS_IR_CAPTURE;
      end else if (tck_rise && state_r == JBS_SHIFT_IR) begin
        ir_shift_r <= {tdi_s2_r, ir_shift_r[`JBS_IR_W-1:1]};
      end else if (tck_fall && state_r == JBS_UPD_IR) begin
        ir_r <= ir_shift_r;
      end
    end
  end

  jbs_dr_sel_type dr_sel;
  assign dr_sel = dr_select(ir_r);

  logic dr_cap, dr_shift, dr_upd;
  assign dr_cap = ce && tck_rise && !trst_act && state_r == JBS_CAP_DR;
  assign dr_shift = ce && tck_rise && !trst_act && state_r == JBS_SHIFT_DR;
  assign dr_upd = ce && tck_fall && !trst_act && state_r == JBS_UPD_DR;

  // Bypass: one stage, captures zero
  logic bypass_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      bypass_r <= `JBS_BYPASS_CAPTURE;
    end else if (dr_sel == JBS_DR_BYPASS) begin
      if (dr_cap) begin
        bypass_r <= `JBS_BYPASS_CAPTURE;
      end else if (dr_shift) begin
        bypass_r <= tdi_s2_r;
      end
    end
  end

  // Identification and user code share one 32-bit shifter
  logic [`JBS_ID_W-1:0] idcode, code_r;
  assign idcode = (`JBS_ID_W'(VERSION) << `JBS_ID_VER_POS)
                | (`JBS_ID_W'(PART_ID) << `JBS_ID_PART_POS)
                | (`JBS_ID_W'(MFR_ID) << `JBS_ID_MFR_POS)
                | (`JBS_ID_W'(1'h1) << `JBS_ID_LSB_POS);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      code_r <= '0;
    end else if (dr_sel == JBS_DR_IDCODE || dr_sel == JBS_DR_USER) begin
      if (dr_cap) begin
        code_r <= (dr_sel == JBS_DR_IDCODE) ? idcode : USER_CODE;
      end else if (dr_shift) begin
        code_r <= {tdi_s2_r, code_r[`JBS_ID_W-1:1]};
      end
    end
  end

  // Boundary scan register; pad inputs read as zero while buffers are off
  logic [NC-1:0] bsr_cap, bsr_upd;
  logic bsr_so, bsr_sel;
  assign bsr_sel = (dr_sel == JBS_DR_BSR);

  always_comb begin
    bsr_cap = '0;
    for (int i = 0; i < `JBS_N_IO; i++) begin
      bsr_cap[i*`JBS_CELLS_PER_IO+`JBS_CELL_IN] = pad_s2_r[i] & io_en;
      bsr_cap[i*`JBS_CELLS_PER_IO+`JBS_CELL_OUT] = core_drive[i].data;
      bsr_cap[i*`JBS_CELLS_PER_IO+`JBS_CELL_OE] = core_drive[i].oe;
    end
  end

  jbs_bsr u_bsr (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .capture(dr_cap && bsr_sel),
    .shift(dr_shift && bsr_sel),
    .update(dr_upd && bsr_sel),
    .ser_in(tdi_s2_r),
    .ser_out(bsr_so),
    .par_in(bsr_cap),
    .par_out(bsr_upd)
  );

  // Test data out: data changes on the falling test clock edge only; test reset drops the enable without waiting for an edge
  logic ser_sel;
  always_comb begin
    unique case (dr_sel)
      JBS_DR_BSR: ser_sel = bsr_so;
      JBS_DR_IDCODE, JBS_DR_USER: ser_sel = code_r[0];
      JBS_DR_BYPASS: ser_sel = bypass_r;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      tdo <= 1'h0;
      tdo_oe <= 1'h0;
    end else if (ce) begin
      if (trst_act) begin
        tdo_oe <= 1'h0;
      end else if (tck_fall) begin
        tdo_oe <= (state_r == JBS_SHIFT_IR) || (state_r == JBS_SHIFT_DR);
        if (state_r == JBS_SHIFT_IR) begin
          tdo <= ir_shift_r[0];
        end else if (state_r == JBS_SHIFT_DR) begin
          tdo <= ser_sel;
        end
      end
    end
  end

  // Pad control; the global enable overrides every test mode, sample included
  logic ext_drive, hiz;
  assign ext_drive = (ir_r == `JBS_OP_EXTEST) || (ir_r == `JBS_OP_CLAMP);
  assign hiz = (ir_r == `JBS_OP_HIGHZ);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      io_en <= 1'h0;
      pad_drive <= '0;
      core_in <= '0;
      tap_state <= JBS_RESET;
    end else if (ce) begin
      io_en <= programmed;
      tap_state <= state_r;
      for (int i = 0; i < `JBS_N_IO; i++) begin
        // Gate on the enable's next value so pads never lead or lag the enable
        if (!programmed) begin
          pad_drive[i] <= '0;
          core_in[i] <= 1'h0;
        end else begin
          core_in[i] <= pad_s2_r[i];
          if (hiz) begin
            pad_drive[i] <= '0;
          end else if (ext_drive) begin
            pad_drive[i].data <= bsr_upd[i*`JBS_CELLS_PER_IO+`JBS_CELL_OUT];
            pad_drive[i].oe <= bsr_upd[i*`JBS_CELLS_PER_IO+`JBS_CELL_OE];
          end else begin
            pad_drive[i] <= core_drive[i];
          end
        end
      end
    end
  end

endmodule // jbs_tap

`default_nettype wire

// ### src/jbs_defines.svh
// Constants for the boundary scan test access port: opcodes, widths, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef JBS_DEFINES_SVH
`define JBS_DEFINES_SVH

// Instruction register
`define JBS_IR_W 8
`define JBS_OP_EXTEST 8'h00
`define JBS_OP_SAMPLE 8'h01
`define JBS_OP_CLAMP 8'h05
`define JBS_OP_HIGHZ 8'h07
`define JBS_OP_USERCODE 8'h0E
`define JBS_OP_IDCODE 8'h0F
`define JBS_OP_BYPASS 8'hFF
`define JBS_IR_CAPTURE 8'h01

// Data registers
`define JBS_ID_W 32
`define JBS_ID_LSB_POS 0
`define JBS_ID_MFR_POS 1
`define JBS_ID_PART_POS 12
`define JBS_ID_VER_POS 28
`define JBS_CELLS_PER_IO 3
`define JBS_CELL_IN 0
`define JBS_CELL_OUT 1
`define JBS_CELL_OE 2
`define JBS_N_IO 4

// Reset values
`define JBS_PIN_IDLE 1'h1
`define JBS_BYPASS_CAPTURE 1'h0

`endif

// ### src/jbs_pkg.sv
// Types shared by the boundary scan test access port modules.
// Assumes jbs_defines.svh is on the include path.
`include "jbs_defines.svh"

package jbs_pkg;

  // TAP controller states, 4-bit encoded
  typedef enum logic [3:0] {
    JBS_EX2_DR = 4'h0,
    JBS_EX1_DR = 4'h1,
    JBS_SHIFT_DR = 4'h2,
    JBS_PAUSE_DR = 4'h3,
    JBS_SEL_IR = 4'h4,
    JBS_UPD_DR = 4'h5,
    JBS_CAP_DR = 4'h6,
    JBS_SEL_DR = 4'h7,
    JBS_EX2_IR = 4'h8,
    JBS_EX1_IR = 4'h9,
    JBS_SHIFT_IR = 4'hA,
    JBS_PAUSE_IR = 4'hB,
    JBS_IDLE = 4'hC,
    JBS_UPD_IR = 4'hD,
    JBS_CAP_IR = 4'hE,
    JBS_RESET = 4'hF
  } jbs_state_type;

  typedef enum logic [1:0] {
    JBS_DR_BYPASS = 2'h0,
    JBS_DR_IDCODE = 2'h1,
    JBS_DR_USER = 2'h2,
    JBS_DR_BSR = 2'h3
  } jbs_dr_sel_type;

  // Test access pins as seen at the device
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jbs_jtag_in_type;

  // One user I/O: core side and pad side
  typedef struct packed {
    logic data;
    logic oe;
  } jbs_drive_type;

endpackage

// ### src/jbs_bsr.sv
// Boundary scan register: three cells per I/O, serial chain plus update latches.
// Assumes one-cycle capture, shift and update strobes on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "jbs_defines.svh"

module jbs_bsr (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Strobes
  input wire logic capture,
  input wire logic shift,
  input wire logic update,
  // Serial path
  input wire logic ser_in,
  output logic ser_out,
  // Parallel path
  input wire logic [`JBS_N_IO*`JBS_CELLS_PER_IO-1:0] par_in,
  output logic [`JBS_N_IO*`JBS_CELLS_PER_IO-1:0] par_out
);
  localparam int W = `JBS_N_IO * `JBS_CELLS_PER_IO;

  logic [W-1:0] chain_r;

  // Top cell is fed from the serial input, cell 0 drives the serial output
  always_ff @(posedge clk) begin
    if (!rstn) begin
      chain_r <= '0;
    end else if (ce) begin
      if (capture) begin
        chain_r <= par_in;
      end else if (shift) begin
        chain_r <= {ser_in, chain_r[W-1:1]};
      end
    end
  end

  // Update latches hold the driven values steady while shifting
  always_ff @(posedge clk) begin
    if (!rstn) begin
      par_out <= '0;
    end else if (ce && update) begin
      par_out <= chain_r;
    end
  end

  assign ser_out = chain_r[0];

endmodule // jbs_bsr

`default_nettype wire

// ### verif/jbs_tap_chk.sv
// Checker: timing relations on the test access port's top-level ports.
// Assumes one clock domain; bound onto every jbs_tap instance below.
`timescale 1ns/100ps
`default_nettype none
`include "jbs_defines.svh"
module jbs_tap_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // Watched ports
  input wire jbs_pkg::jbs_jtag_in_type jtag_in,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic programmed,
  input wire logic io_en,
  input wire logic [`JBS_N_IO-1:0] core_in,
  input wire jbs_pkg::jbs_drive_type [`JBS_N_IO-1:0] pad_drive,
  input wire jbs_pkg::jbs_state_type tap_state
);
  import jbs_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_leave(jbs_state_type st);
    tap_state == st ##1 tap_state != st;
  endsequence
  property p_pads_off; !io_en |-> pad_drive == '0; endproperty
  a_pads_off: assert property (p_pads_off) else $error("pad drive while disabled");
  property p_io_en; ce |=> io_en == $past(programmed); endproperty
  a_io_en: assert property (p_io_en) else $error("pad enable not following config");
  property p_core_off; !io_en |-> core_in == '0; endproperty
  a_core_off: assert property (p_core_off) else $error("input buffer open while off");
  property p_trst; $fell(jtag_in.trst_n) |-> ##[1:5] tap_state == JBS_RESET; endproperty
  a_trst: assert property (p_trst) else $error("test reset ignored");
  property p_oe_shift; $rose(tdo_oe) |-> tap_state inside {JBS_SHIFT_DR, JBS_SHIFT_IR}; endproperty
  a_oe_shift: assert property (p_oe_shift) else $error("data out driven outside shift");
  // Guarded by past reset so a short reset pulse cannot trip it
  property p_tdo_hold; $past(rstn) && !tdo_oe && !$past(tdo_oe) |-> $stable(tdo); endproperty
  a_tdo_hold: assert property (p_tdo_hold) else $error("data out moved while idle");
  property p_reset_exit; s_leave(JBS_RESET) |-> tap_state == JBS_IDLE; endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("bad exit from reset");
  property p_idle_exit; s_leave(JBS_IDLE) |-> tap_state inside {JBS_SEL_DR, JBS_RESET}; endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("bad exit from idle");
  property p_selir_exit; s_leave(JBS_SEL_IR) |-> tap_state inside {JBS_CAP_IR, JBS_RESET}; endproperty
  a_selir_exit: assert property (p_selir_exit) else $error("bad exit from select");
  property p_shift_exit; s_leave(JBS_SHIFT_DR) |-> tap_state inside {JBS_EX1_DR, JBS_RESET}; endproperty
  a_shift_exit: assert property (p_shift_exit) else $error("bad exit from shift");
endmodule // jbs_tap_chk
bind jbs_tap jbs_tap_chk i_jbs_tap_chk (.clk(clk), .rstn(rstn), .ce(ce), .jtag_in(jtag_in),
  .tdo(tdo), .tdo_oe(tdo_oe), .programmed(programmed), .io_en(io_en), .core_in(core_in),
  .pad_drive(pad_drive), .tap_state(tap_state));
`default_nettype wire

// ### verif/jbs_tester.sv
// Partner model: external scan tester driving the test pins, 80 ns test clock.
// Assumes data out settles three system clocks after each test clock fall.
`timescale 1ns/100ps
`default_nettype none
module jbs_tester (
  // Test pins
  output var jbs_pkg::jbs_jtag_in_type jtag,
  input wire logic tdo,
  input wire logic tdo_oe
);
  import jbs_pkg::*;
  logic [31:0] rx;
  logic oe_ok;
  // Clock parked low, pulled-up lines high before the first frame
  initial jtag = 4'h7;
  task automatic step(input logic ms, input logic di, output logic so);
    jtag.tck = 1'b0;
    jtag.tms = ms;
    jtag.tdi = di;
    #40;
    jtag.tck = 1'b1;
    #40;
    // Sampled late in the high phase: data out lags the fall by three system clocks
    so = tdo;
  endtask
  task automatic scan(input logic ir, input int n, input logic [31:0] d);
    logic b;
    #3;
    if (ir) step(1'b1, 1'b1, b);
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    oe_ok = 1'b1;
    rx = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], b);
      rx[i] = b;
      oe_ok &= tdo_oe;
    end
    step(1'b1, 1'b1, b);
    oe_ok &= !tdo_oe;
    step(1'b0, 1'b1, b);
  endtask
  task automatic reset5();
    logic b;
    #3;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
  task automatic hold_reset(input logic v);
    #3;
    jtag.trst_n = v;
  endtask
endmodule // jbs_tester
`default_nettype wire

// ### verif/jbs_tap_bench.sv
// Self-checking bench for the boundary scan test access port.
// Assumes the tester model drives the pins and the checker is bound in.
`timescale 1ns/100ps
`default_nettype none
module jbs_tap_bench;
  import jbs_pkg::*;
  typedef struct {string nm; logic [31:0] v;} jbs_note_type;
  localparam logic [31:0] ID = {4'h1, 16'h1234, 11'h2A5, 1'b1};
  logic clk, rstn, ce, programmed, tdo, tdo_oe, io_en, b;
  jbs_jtag_in_type jtag;
  jbs_drive_type [3:0] core_drive, pad_drive;
  jbs_state_type tap_state;
  logic [3:0] pad_in, core_in;
  logic [31:0] seen, r;
  logic [11:0] p, cap;
  logic [7:0] pd, pe;
  logic [7:0] ops [4] = '{8'h05, 8'hFF, 8'h3C, 8'h07};
  int error_cnt, checked, cycles;
  jbs_note_type exp_q[$];
  jbs_note_type note;
  event res_ev;
  jbs_tap i_jbs_tap (
    .clk(clk), .rstn(rstn), .ce(ce), .jtag_in(jtag), .tdo(tdo), .tdo_oe(tdo_oe),
    .programmed(programmed), .io_en(io_en), .core_drive(core_drive), .core_in(core_in),
    .pad_in(pad_in), .pad_drive(pad_drive), .tap_state(tap_state));
  jbs_tester i_jbs_tester (.jtag(jtag), .tdo(tdo), .tdo_oe(tdo_oe));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(string nm, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wrap_up();
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic post(string nm, logic [31:0] v, logic [31:0] e);
    exp_q.push_back('{nm, e});
    seen = v;
    ->res_ev;
    #1;
  endtask
  task automatic scan(string nm, logic ir, int n, logic [31:0] d, logic [31:0] e);
    i_jbs_tester.scan(ir, n, d);
    post(nm, i_jbs_tester.rx, e);
    post("tdo_oe", {31'h0, i_jbs_tester.oe_ok}, 32'h1);
  endtask
  task automatic wait_clk(int n);
    repeat (n) @(posedge clk);
  endtask
  // Watcher: pairs each result with the oldest note
  initial forever begin
    @(res_ev);
    note = exp_q.pop_front();
    check(note.nm, seen, note.v);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end
  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    programmed = 1'b0;
    core_drive = '0;
    pad_in = '0;
    r = $urandom(37055);
    wait_clk(5);
    rstn <= 1'b1;
    wait_clk(6);
    post("state", {28'h0, tap_state}, 32'hF);
    i_jbs_tester.reset5();
    scan("idcode", 1'b0, 32, '1, ID);
    @(posedge clk);
    core_drive <= '1;
    pad_in <= 4'hF;
    scan("ir", 1'b1, 8, 8'h01, 8'h01);
    wait_clk(8);
    post("pads_off", {20'h0, pad_drive, core_in}, 32'h0);
    @(posedge clk);
    programmed <= 1'b1;
    core_drive <= 8'($urandom);
    pad_in <= 4'($urandom);
    wait_clk(8);
    post("follow", {20'h0, pad_drive, core_in}, {20'h0, core_drive, pad_in});
    for (int i = 0; i < 4; i++) cap[3*i +: 3] = {core_drive[i].oe, core_drive[i].data, pad_in[i]};
    p = 12'($urandom);
    scan("bsr", 1'b0, 12, {20'h0, p}, {20'h0, cap});
    scan("ir", 1'b1, 8, 8'h00, 8'h01);
    for (int i = 0; i < 4; i++) pd[2*i +: 2] = {p[3*i+1], p[3*i+2]};
    wait_clk(8);
    post("extest", {24'h0, pad_drive}, {24'h0, pd});
    pe = pd;
    foreach (ops[k]) begin
      scan("ir", 1'b1, 8, {24'h0, ops[k]}, 8'h01);
      if (ops[k] == 8'h05) post("clamp", {24'h0, pad_drive}, {24'h0, pe});
      pd = 8'($urandom);
      scan("bypass", 1'b0, 8, {24'h0, pd}, {24'h0, pd[6:0], 1'b0});
    end
    wait_clk(8);
    for (int i = 0; i < 4; i++) pd[i] = pad_drive[i].oe;
    post("highz", {28'h0, pd[3:0]}, 32'h0);
    scan("ir", 1'b1, 8, 8'h0E, 8'h01);
    scan("user", 1'b0, 32, '1, 32'h0);
    // Leave the controller parked in shift, then walk out with mode select high
    i_jbs_tester.step(1'b1, 1'b1, b);
    i_jbs_tester.step(1'b0, 1'b1, b);
    i_jbs_tester.step(1'b0, 1'b1, b);
    i_jbs_tester.reset5();
    scan("idcode", 1'b0, 32, '1, ID);
    scan("ir", 1'b1, 8, 8'hFF, 8'h01);
    i_jbs_tester.hold_reset(1'b0);
    wait_clk(8);
    post("trst", {28'h0, tap_state}, 32'hF);
    i_jbs_tester.hold_reset(1'b1);
    wait_clk(4);
    i_jbs_tester.hold_reset(1'b1);
    i_jbs_tester.step(1'b0, 1'b1, b);
    scan("idcode", 1'b0, 32, '1, ID);
    @(posedge clk);
    ce <= 1'b0;
    programmed <= 1'b0;
    wait_clk(8);
    // Enable low freezes everything, the pad enable included
    post("freeze", {30'h0, io_en, tap_state == JBS_IDLE}, 32'h3);
    @(posedge clk);
    ce <= 1'b1;
    wait_clk(8);
    post("unprog", {20'h0, pad_drive, core_in}, 32'h0);
    wrap_up();
  end
endmodule // jbs_tap_bench
`default_nettype wire
